/* lpd_shifter.sv */
`timescale 1ns/100ps
module lpd_shifter
  import lpd_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [10:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Pixel stream from the upstream stages
  input wire logic PIX_VALID_IN,
  input wire logic [23:0] PIX_DATA_IN,
  input wire logic PIX_LOWER_IN,
  input wire logic LINE_START_IN,
  input wire logic FRAME_START_IN,
  // Panel side
  output logic [23:0] PANEL_DATA_OUT,
  output logic PANEL_VALID_OUT
);
  lpd_cfg_t cfg, next_cfg;
  logic [15:0] palette [256];
  logic [15:0] next_palette [256];
  logic [27:0] dreg [NUM_DP];
  logic [27:0] next_dreg [NUM_DP];
  logic [7:0] frame_cnt, next_frame_cnt;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready, pslverr, next_pslverr;
  logic setup, wr_en;
  logic [10:0] addr;

  // APB: registered answer, so every access phase ends at its first edge
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign addr = PADDR_IN;
  assign wr_en = PSEL_IN & PENABLE_IN & pready & PWRITE_IN;

  function automatic logic hit_pal(input logic [10:0] a);
    return a[10];
  endfunction
  function automatic logic hit_dp(input logic [10:0] a);
    return a[10:5] == DITHER_OFS[10:5];
  endfunction

  always_comb begin
    next_cfg = cfg;
    next_palette = palette;
    next_dreg = dreg;
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (setup) begin
      if (hit_pal(addr)) begin
        next_prdata = {16'h0000, palette[addr[9:2]]};
      end else if (hit_dp(addr)) begin
        next_prdata = {4'h0, dreg[addr[4:2]]};
      end else if (addr == CFG_OFS) begin
        next_prdata = {24'h00_0000, cfg};
      end else if (addr == FRAME_OFS) begin
        next_prdata = {24'h00_0000, frame_cnt};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_en) begin
      if (hit_pal(addr)) begin
        next_palette[addr[9:2]] = PWDATA_IN[15:0];
      end else if (hit_dp(addr)) begin
        next_dreg[addr[4:2]] = PWDATA_IN[27:0];
      end else if (addr == CFG_OFS) begin
        next_cfg = lpd_cfg_t'(PWDATA_IN[7:0]);
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg <= CFG_RESET;
      palette <= '{default: PAL_RESET};
      dreg <= '{default: DITHER_RESET};
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      palette <= next_palette;
      dreg <= next_dreg;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  assign PREADY_OUT = pready;
  assign PSLVERR_OUT = pslverr;
  assign PRDATA_OUT = prdata;

  // Frame counting and per-register pattern phase
  logic [2:0] phase [NUM_DP];
  logic [2:0] next_phase [NUM_DP];
  logic [7:0][3:0] cur_pat;

  always_comb begin
    next_frame_cnt = frame_cnt;
    next_phase = phase;
    if (FRAME_START_IN) begin
      next_frame_cnt = frame_cnt + 8'h01;
      for (int i = 0; i < NUM_DP; i++) begin
        next_phase[i] = (phase[i] == DP_LEN[i] - 3'h1) ? 3'h0 : phase[i] + 3'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      frame_cnt <= 8'h00;
      phase <= '{default: 3'h0};
    end else begin
      frame_cnt <= next_frame_cnt;
      phase <= next_phase;
    end
  end

  // First pattern of a register sits in the highest of its DP_LEN nibbles
  always_comb begin
    for (int i = 0; i < NUM_DP; i++) begin
      cur_pat[i] = 4'(dreg[i] >> {DP_LEN[i] - 3'h1 - phase[i], 2'b00});
    end
  end

  function automatic logic dith(input logic [3:0] g, input logic [1:0] m,
                                input logic [7:0][3:0] p);
    logic [3:0] pat;
    pat = 4'h0;
    case (g)
      4'hF: pat = 4'hF;
      4'hE: pat = p[DP_SIX_SEVENTHS];
      4'hD: pat = p[DP_FOUR_FIFTHS];
      4'hC: pat = p[DP_THREE_QUARTERS];
      4'hB: pat = p[DP_FIVE_SEVENTHS];
      4'hA: pat = p[DP_TWO_THIRDS];
      4'h9: pat = p[DP_THREE_FIFTHS];
      4'h8: pat = p[DP_FOUR_SEVENTHS];
      4'h7: pat = ~p[DP_ONE_HALF];
      4'h6: pat = ~p[DP_FOUR_SEVENTHS];
      4'h5: pat = ~p[DP_THREE_FIFTHS];
      4'h4: pat = ~p[DP_TWO_THIRDS];
      4'h3: pat = ~p[DP_THREE_QUARTERS];
      4'h2: pat = ~p[DP_FOUR_FIFTHS];
      4'h1: pat = ~p[DP_SIX_SEVENTHS];
      default: pat = 4'h0;
    endcase
    return pat[2'd3 - m];
  endfunction

  // Stage A: palette lookup and component selection
  logic a_valid, a_lower, a_tftpal;
  logic [3:0] a_gr, a_gg, a_gb;
  logic [23:0] a_tft;
  logic n_valid, n_lower, n_tftpal;
  logic [3:0] n_gr, n_gg, n_gb;
  logic [23:0] n_tft;
  logic [7:0] pix_idx;
  logic pal_use;
  lpd_entry_t ent;

  always_comb begin
    case (cfg.bits_per_pixel)
      BPP_1: pix_idx = {7'h00, PIX_DATA_IN[0]};
      BPP_2: pix_idx = {6'h00, PIX_DATA_IN[1:0]};
      BPP_4: pix_idx = {4'h0, PIX_DATA_IN[3:0]};
      default: pix_idx = PIX_DATA_IN[7:0];
    endcase
    // Mono at 4 bpp and anything at 16 or 24 bpp skips the table
    pal_use = (cfg.bits_per_pixel <= BPP_8) &&
              !(cfg.display_type_sel == DISP_MONO && cfg.bits_per_pixel == BPP_4);
    ent = pal_use ? lpd_entry_t'(palette[pix_idx]) : lpd_entry_t'(PIX_DATA_IN[15:0]);
    n_valid = PIX_VALID_IN & ~LINE_START_IN;
    n_lower = PIX_LOWER_IN & cfg.scan_select;
    n_tftpal = pal_use && cfg.display_type_sel == DISP_TFT;
    n_gr = ent.red[4:1];
    n_gg = ent.green[4:1];
    n_gb = ent.blue[4:1];
    if (cfg.display_type_sel == DISP_MONO && !pal_use) begin
      n_gr = PIX_DATA_IN[3:0];
    end
    if (cfg.bits_per_pixel == BPP_24) begin
      n_tft = PIX_DATA_IN;
    end else begin
      n_tft = {ent.blue, ent.intensity, 2'b00, ent.green, ent.intensity, 2'b00,
               ent.red, ent.intensity, 2'b00};
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      a_valid <= 1'b0;
      a_lower <= 1'b0;
      a_tftpal <= 1'b0;
      a_gr <= 4'h0;
      a_gg <= 4'h0;
      a_gb <= 4'h0;
      a_tft <= 24'h00_0000;
    end else begin
      a_valid <= n_valid;
      a_lower <= n_lower;
      a_tftpal <= n_tftpal;
      a_gr <= n_gr;
      a_gg <= n_gg;
      a_gb <= n_gb;
      a_tft <= n_tft;
    end
  end

  // Stage B: dither and pack, one accumulator per panel half
  logic [1:0] pos [2];
  logic [1:0] next_pos [2];
  logic [15:0] acc [2];
  logic [15:0] next_acc [2];
  logic [4:0] cnt [2];
  logic [4:0] next_cnt [2];
  logic [7:0] upper_word, next_upper;
  logic [23:0] panel_data, next_data;
  logic panel_valid, next_valid, out_tftpal, next_out_tftpal;
  logic [4:0] hw, nbits, sum, sft;
  logic [2:0] bits3;
  logic [15:0] sh, mask, word;
  logic colour;

  always_comb begin
    // Lane width per half; dual scan splits the 8- and 16-bit buses in two
    case ({cfg.scan_select, cfg.panel_bus_width})
      {1'b0, WIDTH_4}: hw = 5'd4;
      {1'b1, WIDTH_8}: hw = 5'd4;
      default: hw = 5'd8;
    endcase
    colour = cfg.display_type_sel == DISP_COLOR;
    next_pos = pos;
    next_acc = acc;
    next_cnt = cnt;
    next_upper = upper_word;
    next_data = panel_data;
    next_valid = 1'b0;
    next_out_tftpal = out_tftpal;
    nbits = colour ? 5'd3 : 5'd1;
    if (colour) begin
      bits3 = {dith(a_gr, pos[a_lower], cur_pat),
               dith(a_gg, 2'(pos[a_lower] + 2'd1), cur_pat),
               dith(a_gb, 2'(pos[a_lower] + 2'd2), cur_pat)};
    end else begin
      bits3 = {2'b00, dith(a_gr, pos[a_lower], cur_pat)};
    end
    sh = 16'((acc[a_lower] << nbits) | {13'h0000, bits3});
    sum = cnt[a_lower] + nbits;
    sft = sum - hw;
    mask = 16'((17'h1_0000 >> (5'd16 - hw)) - 17'h0_0001);
    word = (sh >> sft) & mask;
    if (LINE_START_IN) begin
      next_pos = '{default: 2'b00};
      next_acc = '{default: 16'h0000};
      next_cnt = '{default: 5'd0};
    end else if (a_valid && cfg.display_type_sel == DISP_TFT) begin
      next_data = a_tft;
      next_valid = 1'b1;
      next_out_tftpal = a_tftpal;
    end else if (a_valid) begin
      next_out_tftpal = 1'b0;
      next_pos[a_lower] = 2'(pos[a_lower] + nbits[1:0]);
      next_acc[a_lower] = sh;
      if (sum >= hw) begin
        next_cnt[a_lower] = sft;
        if (cfg.scan_select && !a_lower) begin
          next_upper = word[7:0];
        end else if (cfg.scan_select) begin
          next_data = {8'h00, 16'((upper_word << hw) | word[7:0])};
          next_valid = 1'b1;
        end else begin
          next_data = {8'h00, word};
          next_valid = 1'b1;
        end
      end else begin
        next_cnt[a_lower] = sum;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pos <= '{default: 2'b00};
      acc <= '{default: 16'h0000};
      cnt <= '{default: 5'd0};
      upper_word <= 8'h00;
      panel_data <= 24'h00_0000;
      panel_valid <= 1'b0;
      out_tftpal <= 1'b0;
    end else begin
      pos <= next_pos;
      acc <= next_acc;
      cnt <= next_cnt;
      upper_word <= next_upper;
      panel_data <= next_data;
      panel_valid <= next_valid;
      out_tftpal <= next_out_tftpal;
    end
  end

  assign PANEL_DATA_OUT = panel_data;
  assign PANEL_VALID_OUT = panel_valid;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  a_apb_ready_one: assert property (setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("APB answer not one cycle after setup");
  a_pal_write_read: assert property (wr_en && hit_pal(addr) |=>
      palette[$past(addr[9:2])] == $past(PWDATA_IN[15:0]))
    else $error("palette entry not written");
  a_pal_upper_zero: assert property (PREADY_OUT && !PSLVERR_OUT && $past(hit_pal(addr))
      |-> PRDATA_OUT[31:16] == 16'h0000)
    else $error("palette read upper half not zero");
  a_tft_unused_zero: assert property (PANEL_VALID_OUT && out_tftpal |->
      PANEL_DATA_OUT[17:16] == 2'b00 && PANEL_DATA_OUT[9:8] == 2'b00
      && PANEL_DATA_OUT[1:0] == 2'b00)
    else $error("unused TFT lines not zero");
  a_tft_intensity: assert property (PANEL_VALID_OUT && out_tftpal |->
      PANEL_DATA_OUT[18] == PANEL_DATA_OUT[10] && PANEL_DATA_OUT[10] == PANEL_DATA_OUT[2])
    else $error("intensity bit differs between components");
  a_gray_extremes: assert property (a_valid && !colour |->
      (a_gr != 4'hF || bits3[0]) && (a_gr != 4'h0 || !bits3[0]))
    else $error("gray 15 or 0 dithered");
  a_phase_wrap: assert property (FRAME_START_IN && phase[DP_SIX_SEVENTHS] == 3'h6 |=>
      phase[DP_SIX_SEVENTHS] == 3'h0)
    else $error("pattern sequence does not wrap");
  a_frame_step: assert property (FRAME_START_IN |=> frame_cnt == 8'($past(frame_cnt) + 8'h01))
    else $error("frame counter did not advance");
  a_colour_pos: assert property (a_valid && colour && !LINE_START_IN &&
      cfg.display_type_sel == DISP_COLOR |=>
      pos[$past(a_lower)] == 2'($past(pos[a_lower]) + 2'd3))
    else $error("colour position not advanced by three");
  a_bypass_24: assert property (PIX_VALID_IN && cfg.bits_per_pixel == BPP_24 &&
      !LINE_START_IN |=> a_tft == $past(PIX_DATA_IN))
    else $error("24 bpp pixel not passed through");

  c_tft_out: cover property (PANEL_VALID_OUT && out_tftpal);
  c_colour_out: cover property (PANEL_VALID_OUT && colour && !cfg.scan_select);
  c_dual_out: cover property (PANEL_VALID_OUT && cfg.scan_select);
  c_unmapped: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule

/* lpd_pkg.sv */
package lpd_pkg;
  // APB byte offsets
  localparam logic [10:0] CFG_OFS = 11'h000;
  localparam logic [10:0] FRAME_OFS = 11'h004;
  localparam logic [10:0] DITHER_OFS = 11'h020;
  localparam logic [10:0] PAL_OFS = 11'h400;
  // Configuration field positions
  localparam int CFG_DISP_LSB = 0;
  localparam int CFG_SCAN_BIT = 2;
  localparam int CFG_WIDTH_LSB = 3;
  localparam int CFG_BPP_LSB = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] PAL_RESET = 16'h0000;
  localparam logic [27:0] DITHER_RESET = 28'h000_0000;
  // display_type_sel codes
  localparam logic [1:0] DISP_TFT = 2'h0;
  localparam logic [1:0] DISP_MONO = 2'h1;
  localparam logic [1:0] DISP_COLOR = 2'h2;
  // panel_bus_width codes
  localparam logic [1:0] WIDTH_4 = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  // bits_per_pixel codes
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_2 = 3'h1;
  localparam logic [2:0] BPP_4 = 3'h2;
  localparam logic [2:0] BPP_8 = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [2:0] BPP_24 = 3'h5;
  // Dither register indices; order of the dither_pattern_regs
  localparam int NUM_DP = 8;
  localparam int DP_ONE_HALF = 0;
  localparam int DP_FOUR_SEVENTHS = 1;
  localparam int DP_THREE_FIFTHS = 2;
  localparam int DP_TWO_THIRDS = 3;
  localparam int DP_FIVE_SEVENTHS = 4;
  localparam int DP_THREE_QUARTERS = 5;
  localparam int DP_FOUR_FIFTHS = 6;
  localparam int DP_SIX_SEVENTHS = 7;
  // Patterns per register, equal to the duty cycle denominator
  localparam logic [2:0] DP_LEN [NUM_DP] = '{3'h2, 3'h7, 3'h5, 3'h3, 3'h7, 3'h4, 3'h5, 3'h7};

  typedef struct packed {
    logic [2:0] bits_per_pixel;
    logic [1:0] panel_bus_width;
    logic scan_select;
    logic [1:0] display_type_sel;
  } lpd_cfg_t;

  typedef struct packed {
    logic intensity;
    logic [4:0] blue;
    logic [4:0] green;
    logic [4:0] red;
  } lpd_entry_t;
endpackage

/* lpd_panel_model.sv */
`timescale 1ns/100ps
module lpd_panel_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Panel data bus from the shifter
  input wire logic [23:0] data_in,
  input wire logic valid_in
);
  logic [23:0] words[$];

  // No back-pressure on a real panel, so every strobed word is latched
  always @(posedge clk_in) begin
    if (rstn_in === 1'b1 && valid_in === 1'b1) begin
      words.push_back(data_in);
    end
  end
endmodule

/* tb_lpd_shifter.sv */
`timescale 1ns/100ps
module tb_lpd_shifter
  import lpd_pkg::*;
;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [10:0] paddr = 11'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pv = 1'b0;
  logic pl = 1'b0;
  logic [23:0] pd = 24'h00_0000;
  logic ls = 1'b0;
  logic fs = 1'b0;
  logic [23:0] panel_data;
  logic panel_valid;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int frames = 0;
  logic [15:0] pal [256];
  logic [27:0] dp [NUM_DP];
  int bits [6] = '{1, 2, 4, 8, 16, 24};
  // Gray 1..7 reuse the complementary register
  int low_idx [8] = '{0, 7, 6, 5, 3, 2, 1, 0};

  lpd_shifter u_lpd_shifter (
    .REF_CLK_IN(clk),
    .RSTN_IN(rstn),
    .PSEL_IN(psel),
    .PENABLE_IN(penable),
    .PWRITE_IN(pwrite),
    .PADDR_IN(paddr),
    .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata),
    .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr),
    .PIX_VALID_IN(pv),
    .PIX_DATA_IN(pd),
    .PIX_LOWER_IN(pl),
    .LINE_START_IN(ls),
    .FRAME_START_IN(fs),
    .PANEL_DATA_OUT(panel_data),
    .PANEL_VALID_OUT(panel_valid)
  );

  lpd_panel_model u_lpd_panel_model (
    .clk_in(clk),
    .rstn_in(rstn),
    .data_in(panel_data),
    .valid_in(panel_valid)
  );

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [10:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [10:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'h0000_0000, e}, {31'h0000_0000, exp_err});
  endtask

  task automatic pulse_start(input logic frame);
    @(posedge clk);
    if (frame) begin
      fs <= 1'b1;
      frames++;
    end else begin
      ls <= 1'b1;
    end
    @(posedge clk);
    fs <= 1'b0;
    ls <= 1'b0;
  endtask

  task automatic end_burst();
    @(posedge clk);
    pv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic take(output logic [23:0] w);
    w = 24'h00_0000;
    if (u_lpd_panel_model.words.size() == 0) begin
      n_fail++;
      $display("[FAIL] %0t panel word missing", $time);
    end else begin
      w = u_lpd_panel_model.words.pop_front();
    end
  endtask

  function automatic logic [23:0] tft(input logic [15:0] e);
    return {e[14:10], e[15], 2'b00, e[9:5], e[15], 2'b00, e[4:0], e[15], 2'b00};
  endfunction

  function automatic logic on_bit(input int g, input int x);
    int i;
    int len;
    logic [3:0] pat;
    if (g == 15) return 1'b1;
    if (g == 0) return 1'b0;
    i = (g >= 8) ? g - 7 : low_idx[g];
    len = int'(DP_LEN[i]);
    pat = dp[i][4 * len - 1 - 4 * (frames % len) -: 4];
    if (g <= 7) pat = ~pat;
    return pat[3 - x % 4];
  endfunction

  initial begin
    logic [23:0] w;
    logic [23:0] exp;
    logic [23:0] q[$];
    int gray[$];
    int gl[$];
    logic [7:0] idx;
    int ppw;
    void'($urandom(51264));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(CFG_OFS, {24'h00_0000, CFG_RESET}, 1'b0);
    rd_chk(PAL_OFS + 11'h3FC, {16'h0000, PAL_RESET}, 1'b0);
    rd_chk(DITHER_OFS, {4'h0, DITHER_RESET}, 1'b0);
    rd_chk(FRAME_OFS, 32'h0000_0000, 1'b0);
    wr(11'h014, 32'hFFFF_FFFF);
    rd_chk(11'h014, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 256; i++) begin
      pal[i] = 16'($urandom);
      wr(PAL_OFS + 11'(4 * i), {16'($urandom), pal[i]});
    end
    for (int i = 0; i < 256; i++) begin
      rd_chk(PAL_OFS + 11'(4 * i), {16'h0000, pal[i]}, 1'b0);
    end
    for (int i = 0; i < NUM_DP; i++) begin
      dp[i] = 28'($urandom);
      wr(DITHER_OFS + 11'(4 * i), {4'($urandom), dp[i]});
      rd_chk(DITHER_OFS + 11'(4 * i), {4'h0, dp[i]}, 1'b0);
    end
    for (int b = 0; b < 6; b++) begin
      wr(CFG_OFS, {24'h00_0000, 3'(b), WIDTH_4, 1'b0, DISP_TFT});
      rd_chk(CFG_OFS, {24'h00_0000, 3'(b), WIDTH_4, 1'b0, DISP_TFT}, 1'b0);
      pulse_start(1'b0);
      q.delete();
      for (int k = 0; k < 8; k++) begin
        q.push_back(24'($urandom) & 24'((1 << bits[b]) - 1));
        @(posedge clk);
        pv <= 1'b1;
        pd <= q[k];
      end
      end_burst();
      for (int k = 0; k < 8; k++) begin
        take(w);
        exp = (b < 4) ? tft(pal[q[k][7:0]]) : tft(q[k][15:0]);
        if (b == 5) exp = q[k];
        check(w, exp);
      end
    end
    for (int md = 0; md < 3; md++) begin
      ppw = (md == 0) ? 4 : 8;
      wr(CFG_OFS, {24'h00_0000, (md == 0) ? BPP_4 : 3'(md - 1),
                   (md == 0) ? WIDTH_4 : WIDTH_8, 1'b0, DISP_MONO});
      for (int f = 0; f < 8; f++) begin
        pulse_start(1'b1);
        pulse_start(1'b0);
        q.delete();
        gray.delete();
        for (int k = 0; k < 16; k++) begin
          q.push_back(24'($urandom) & ((md == 0) ? 24'h00_000F : 24'((1 << md) - 1)));
          gray.push_back((md == 0) ? int'(q[k][3:0]) : int'(pal[q[k][7:0]][4:1]));
          @(posedge clk);
          pv <= 1'b1;
          pd <= q[k];
        end
        end_burst();
        for (int n = 0; n < 16 / ppw; n++) begin
          take(w);
          exp = 24'h00_0000;
          for (int k = 0; k < ppw; k++) begin
            exp[ppw - 1 - k] = on_bit(gray[n * ppw + k], n * ppw + k);
          end
          check(w & 24'((1 << ppw) - 1), exp);
        end
      end
    end
    for (int cw = 0; cw < 2; cw++) begin
      ppw = (cw == 0) ? 4 : 8;
      wr(CFG_OFS, {24'h00_0000, BPP_8, (cw == 0) ? WIDTH_4 : WIDTH_8, 1'b0, DISP_COLOR});
      pulse_start(1'b0);
      gray.delete();
      for (int k = 0; k < 8; k++) begin
        idx = 8'($urandom);
        gray.push_back(int'(pal[idx][4:1]));
        gray.push_back(int'(pal[idx][9:6]));
        gray.push_back(int'(pal[idx][14:11]));
        @(posedge clk);
        pv <= 1'b1;
        pd <= {16'($urandom), idx};
      end
      end_burst();
      for (int n = 0; n < 24 / ppw; n++) begin
        take(w);
        exp = 24'h00_0000;
        for (int t = 0; t < ppw; t++) begin
          exp[ppw - 1 - t] = on_bit(gray[n * ppw + t], n * ppw + t);
        end
        check(w, exp);
      end
    end
    // Upper and lower halves alternate; each half counts its own positions
    for (int dw = 0; dw < 2; dw++) begin
      ppw = (dw == 0) ? 4 : 8;
      wr(CFG_OFS, {24'h00_0000, BPP_1, (dw == 0) ? WIDTH_8 : WIDTH_16, 1'b1, DISP_MONO});
      pulse_start(1'b0);
      gray.delete();
      gl.delete();
      for (int k = 0; k < 16; k++) begin
        idx = 8'($urandom & 1);
        if (k % 2 == 0) begin
          gray.push_back(int'(pal[idx][4:1]));
        end else begin
          gl.push_back(int'(pal[idx][4:1]));
        end
        @(posedge clk);
        pv <= 1'b1;
        pl <= 1'(k % 2);
        pd <= {16'($urandom), idx};
      end
      end_burst();
      for (int n = 0; n < 8 / ppw; n++) begin
        take(w);
        exp = 24'h00_0000;
        for (int t = 0; t < ppw; t++) begin
          exp[2 * ppw - 1 - t] = on_bit(gray[n * ppw + t], n * ppw + t);
          exp[ppw - 1 - t] = on_bit(gl[n * ppw + t], n * ppw + t);
        end
        check(w, exp);
      end
    end
    check(32'(u_lpd_panel_model.words.size()), 32'h0000_0000);
    rd_chk(FRAME_OFS, 32'(frames % 256), 1'b0);
    report_and_stop();
  end
endmodule
